// ---- pmc_pkg.sv ----
// Constants, types and decode helpers for the power and mode controller.
// Assumes a 100 MHz system clock and an 8-bit register port.
package pmc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ  = 100;
  localparam int DEB_US   = 1000;
  localparam int ON_US    = 2000;
  localparam int OFF_US   = 10000;
  localparam int LONG_MS  = 2400;
  localparam int DEB_CYC  = DEB_US * CLK_MHZ;
  localparam int ON_CYC   = ON_US * CLK_MHZ;
  localparam int OFF_CYC  = OFF_US * CLK_MHZ;
  localparam int LONG_CYC = LONG_MS * 1000 * CLK_MHZ;
  localparam int CNT_W    = 28;
  localparam int DEB_W    = 17;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] OFS_SHR_LO0 = 8'h10;
  localparam logic [7:0] OFS_SHR_HI0 = 8'h17;
  localparam logic [7:0] OFS_SHR_LO1 = 8'h30;
  localparam logic [7:0] OFS_SHR_HI1 = 8'h35;
  localparam logic [7:0] OFS_SER_CTL = 8'h3d;
  localparam logic [7:0] OFS_STATUS  = 8'h3e;
  localparam logic [7:0] OFS_FUSECMD = 8'h3f;
  localparam int         SHR_N       = 14;
  localparam logic [7:0] SHR_RST     = 8'h00;
  // Shadow indices
  localparam int IDX_MIC_GAIN = 0;
  localparam int IDX_LSN_GAIN = 1;
  localparam int IDX_LSN_CFG  = 2;
  localparam int IDX_PBO_CFG  = 3;
  localparam int IDX_OPAMP    = 4;
  localparam int IDX_SCHEME   = 5;
  // Field positions
  localparam int B_SW_POWER   = 0;
  localparam int B_SW_LISTEN  = 1;
  localparam int B_LSN_BLOCK  = 2;
  localparam int B_LSN_MUX    = 0;
  localparam int B_LSN_MUTE   = 1;
  localparam int B_PBO_MUTE   = 0;
  localparam int B_PBO_MIXER  = 1;
  localparam int B_OPAMP_EN   = 0;
  localparam int B_LSN_BIT    = 0;
  localparam int B_KEEP_BIT   = 1;
  localparam int B_SER_SEL    = 2;
  localparam int B_STORE      = 0;
  localparam int B_LOAD       = 1;
  localparam logic [1:0] FUSE_PASSES = 2'h3;
  // Synchroniser lanes
  localparam int PIN_MODE = 0;
  localparam int PIN_MID  = 1;
  localparam int PIN_BTN  = 2;
  localparam int PIN_NCUT = 3;
  localparam int PIN_FLT  = 4;
  localparam int PIN_TD   = 5;
  localparam int PIN_TC   = 6;
  // Reported mode codes
  localparam logic [1:0] MD_OFF = 2'h0;
  localparam logic [1:0] MD_ANC = 2'h1;
  localparam logic [1:0] MD_LSN = 2'h2;
  localparam logic [1:0] MD_PBO = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {ST_OFF, ST_START, ST_ANC, ST_LISTEN, ST_PBO} pmc_st_t;

  typedef struct packed {
    logic       power_en;
    logic       anc_en;
    logic       mic_en;
    logic       line_en;
    logic       hp_en;
    logic       opamp_en;
    logic       mux_alt;
    logic       line_mute;
    logic       mixer_sel;
    logic [7:0] mic_gain;
  } pmc_amp_t;

  // Returns {hit, index} for a shadow register address
  function automatic logic [4:0] pmc_sidx(input logic [7:0] a);
    logic [7:0] t;
    t = 8'h00;
    if (a >= OFS_SHR_LO0 && a <= OFS_SHR_HI0) begin
      t = a - OFS_SHR_LO0;
      return {1'b1, t[3:0]};
    end
    if (a >= OFS_SHR_LO1 && a <= OFS_SHR_HI1) begin
      t = a - OFS_SHR_LO1 + 8'h08;
      return {1'b1, t[3:0]};
    end
    return 5'h00;
  endfunction

endpackage

// ---- pmc_switch_model.sv ----
// Model of the slide switches, push buttons and trim box around the controller.
// Assumes the bench clock; every pin changes right after a rising edge.
module pmc_switch_model (
  input  wire logic sys_clk,
  output      logic mode_sense_pin,
  output      logic mode_sense_mid,
  output      logic listen_button,
  output      logic trim_data_pin,
  output      logic trim_clock_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    mode_sense_pin = 1'b0;
    mode_sense_mid = 1'b0;
    listen_button  = 1'b0;
    trim_data_pin  = 1'b0;
    trim_clock_pin = 1'b0;
  end

  ////////////////////////////////////////////////////////////
  // Slide switch positions: upper and middle comparator levels
  task automatic set_lvl(input logic hi, input logic mid);
    @(posedge sys_clk);
    mode_sense_pin <= hi;
    mode_sense_mid <= mid;
  endtask

  // Press of mode pin or listen button held for n cycles; long mode pin holds power the part on or off
  task automatic press(input logic lsn, input int n);
    @(posedge sys_clk);
    if (lsn) listen_button <= 1'b1;
    else mode_sense_pin <= 1'b1;
    repeat (n) @(posedge sys_clk);
    if (lsn) listen_button <= 1'b0;
    else mode_sense_pin <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////
  // Trim box: address byte then data byte, msb first, slow clock
  task automatic trim_write(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] w;
    w = {a, d};
    for (int i = 15; i >= 0; i--) begin
      @(posedge sys_clk);
      trim_data_pin <= w[i];
      repeat (4) @(posedge sys_clk);
      trim_clock_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      trim_clock_pin <= 1'b0;
    end
    repeat (8) @(posedge sys_clk);
  endtask
endmodule // pmc_switch_model

// ---- pmc_top.sv ----
// Power sequencing and operating mode controller with fuse-backed shadow
// registers. Assumes pins arrive asynchronously and an 8-bit register port.
//
// Notes on behaviour
// - Negative rail fault flag powers the device down from any running state.
// - Mode pin high while off starts the automatic start-up sequence.
// - Stand-alone mode is always one of off, cancelling, listen, playback.
// - Listen state uses own mic gain, optional mux switch and line mute.
// - Under serial control the listen bit selects listen state.
// - Playback state: cancelling and mic off, line and headphone amplifiers on, op-amp per its bit.
// - Scheme bits: 00 button, 01 forbidden, 10 slider, 11 full slider.
// - Full slider: three pin levels select off, on or listen.
// - Slider: each listen button press toggles a latched listen state.
// - Button: press powers up from off, hold 2.4 s shuts down.
// - Button: short press while active toggles listen state.
// - Button: listen block bit stops short presses entering listen state.
// - Noise cut pin sampled at start-up picks cancelling or playback state.
// - Playback line mute and mixer input follow the playback config register.
// - Entering playback shuts the mic amp; op-amps stay separately controlled.
// - Shadow registers accept unlimited writes and clear at power-off.
// - Shadow registers reachable from register port and trim pins.
// - Start-up copies fuse contents into the shadow registers.
// - Three fuse passes, three mic gain fuse sets.
// - Fuse bits only go from 0 to 1, never back.
// - Slider: mode pin low for 10 ms turns the device off.
// - Serial host clears keep bit after setting serial select to shut down.
module pmc_top
  import pmc_pkg::*;
#(
  parameter int DEB_CNT  = DEB_CYC,
  parameter int ON_CNT   = ON_CYC,
  parameter int OFF_CNT  = OFF_CYC,
  parameter int LONG_CNT = LONG_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       mode_sense_pin,
  input  wire logic       mode_sense_mid,
  input  wire logic       listen_button,
  input  wire logic       noise_cut_select_pin,
  input  wire logic       negrail_overvolt_flag,
  input  wire logic       trim_data_pin,
  input  wire logic       trim_clock_pin,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output      logic [7:0] reg_rdata,
  output      logic [1:0] op_mode,
  output      pmc_amp_t   amp_ctl
);

  typedef struct packed {
    logic [6:0]              s1;
    logic [6:0]              s2;
    logic [2:0][DEB_W-1:0]   dcnt;
    logic [2:0]              deb;
    logic                    pin_prev;
    logic                    btn_prev;
    logic [CNT_W-1:0]        hi_cnt;
    logic [CNT_W-1:0]        lo_cnt;
    logic                    armed;
    logic                    lsn;
    logic                    base_pbo;
    pmc_st_t                 st;
    logic [SHR_N-1:0][7:0]   shr;
    logic [SHR_N-1:0][7:0]   fuse;
    logic [2:0][7:0]         gset;
    logic [1:0]              pass;
    logic [2:0]              ser;
    logic [15:0]             tsh;
    logic [3:0]              tcnt;
    logic                    tc_prev;
    logic [7:0]              rdata;
    logic [1:0]              mode;
    pmc_amp_t                amp;
  } pmc_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic [1:0] rsync_q;
  logic       rst_n;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rsync_q <= 2'h0;
    end else begin
      rsync_q <= {rsync_q[0], 1'b1};
    end
  end
  assign rst_n = rsync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  pmc_state_t q;
  pmc_state_t d;
  logic [1:0] scheme;
  logic       full;
  logic       slider;
  logic       serial;
  logic       pin_on;
  logic       fault;
  logic       btn_rise;
  logic       pin_fall;
  logic       running;
  logic [4:0] bw;
  logic [4:0] tw;
  logic       t_fire;
  logic [15:0] tword;
  logic [1:0] pidx;

  always_comb begin
    d = q;
    bw = 5'h00;
    tw = 5'h00;
    tword = 16'h0000;
    pidx = 2'h0;
    d.s1 = {trim_clock_pin, trim_data_pin, negrail_overvolt_flag,
            noise_cut_select_pin, listen_button, mode_sense_mid, mode_sense_pin};
    d.s2 = q.s1;
    // Debounce mode level and button inputs
    for (int i = 0; i < 3; i++) begin
      if (q.s2[i] == q.deb[i]) begin
        d.dcnt[i] = '0;
      end else if (q.dcnt[i] >= DEB_W'(DEB_CNT - 1)) begin
        d.deb[i] = q.s2[i];
        d.dcnt[i] = '0;
      end else begin
        d.dcnt[i] = q.dcnt[i] + 1'b1;
      end
    end
    scheme = {q.shr[IDX_SCHEME][B_SW_POWER], q.shr[IDX_SCHEME][B_SW_LISTEN]};
    full   = (scheme == 2'h3);
    slider = (scheme == 2'h2);
    serial = q.ser[B_SER_SEL];
    fault  = q.s2[PIN_FLT];
    pin_on = full ? q.deb[PIN_MID] : q.deb[PIN_MODE];
    btn_rise = q.deb[PIN_BTN] & ~q.btn_prev;
    pin_fall = q.pin_prev & ~pin_on;
    running  = (q.st == ST_ANC) || (q.st == ST_LISTEN) || (q.st == ST_PBO);
    d.pin_prev = pin_on;
    d.btn_prev = q.deb[PIN_BTN];
    // Hold and release timers
    if (pin_on) begin
      d.lo_cnt = '0;
      if (q.hi_cnt != '1) begin
        d.hi_cnt = q.hi_cnt + 1'b1;
      end
    end else begin
      d.hi_cnt = '0;
      if (q.lo_cnt != '1) begin
        d.lo_cnt = q.lo_cnt + 1'b1;
      end
    end
    if (!pin_on) begin
      d.armed = 1'b1;
    end

    // Operating state machine
    case (q.st)
      ST_OFF: begin
        if (serial ? q.ser[B_KEEP_BIT] : (q.armed && q.hi_cnt > CNT_W'(ON_CNT))) begin
          d.st = ST_START;
          d.armed = 1'b0;
          d.lsn = 1'b0;
        end
      end
      ST_START: begin
        // Fuse load and noise cut sampling
        for (int i = 0; i < SHR_N; i++) begin
          d.shr[i] = q.fuse[i];
        end
        pidx = q.pass - 2'h1;
        d.shr[IDX_MIC_GAIN] = (q.pass == 2'h0) ? SHR_RST : q.gset[pidx];
        d.base_pbo = ~q.s2[PIN_NCUT];
        d.st = q.s2[PIN_NCUT] ? ST_ANC : ST_PBO;
        if (fault) begin
          d.st = ST_OFF;
        end
      end
      ST_ANC, ST_LISTEN, ST_PBO: begin
        if (serial) begin
          d.lsn = q.ser[B_LSN_BIT];
        end else if (full) begin
          d.lsn = q.deb[PIN_MODE];
        end else if (slider) begin
          if (btn_rise) begin
            d.lsn = ~q.lsn;
          end
        end else if (pin_fall && q.armed && q.hi_cnt < CNT_W'(LONG_CNT)) begin
          if (q.lsn || !q.shr[IDX_SCHEME][B_LSN_BLOCK]) begin
            d.lsn = ~q.lsn;
          end
        end
        d.st = d.lsn ? ST_LISTEN : (q.base_pbo ? ST_PBO : ST_ANC);
        if (fault) begin
          d.st = ST_OFF;
        end else if (serial) begin
          if (!q.ser[B_KEEP_BIT]) begin
            d.st = ST_OFF;
          end
        end else if (full || slider) begin
          if (q.lo_cnt >= CNT_W'(OFF_CNT)) begin
            d.st = ST_OFF;
          end
        end else if (q.armed && q.hi_cnt >= CNT_W'(LONG_CNT)) begin
          d.st = ST_OFF;
          d.armed = 1'b0;
        end
        if (d.st == ST_OFF) begin
          d.lsn = 1'b0;
        end
      end
      default: begin
        d.st = ST_OFF;
      end
    endcase
    if (d.st == ST_OFF && q.st != ST_OFF) begin
      d.shr = {SHR_N{SHR_RST}};  // Volatile shadow lost at power-down
    end

    ////////////////////////////////////////////////////////////////////////
    // Trim pin serial writes: 8 address bits then 8 data bits
    d.tc_prev = q.s2[PIN_TC];
    t_fire = 1'b0;
    if (q.s2[PIN_TC] && !q.tc_prev) begin
      tword = {q.tsh[14:0], q.s2[PIN_TD]};
      d.tsh = tword;
      d.tcnt = q.tcnt + 1'b1;
      t_fire = (q.tcnt == 4'hf);
    end
    if (t_fire) begin
      tw = pmc_sidx(tword[15:8]);
    end

    ////////////////////////////////////////////////////////////////////////
    // Fuse commands
    if (reg_wr && reg_addr == OFS_FUSECMD) begin
      if (reg_wdata[B_LOAD]) begin
        for (int i = 0; i < SHR_N; i++) begin
          d.shr[i] = q.fuse[i];
        end
        pidx = q.pass - 2'h1;
        d.shr[IDX_MIC_GAIN] = (q.pass == 2'h0) ? SHR_RST : q.gset[pidx];
      end else if (reg_wdata[B_STORE] && q.pass != FUSE_PASSES) begin
        for (int i = 1; i < SHR_N; i++) begin
          d.fuse[i] = q.fuse[i] | q.shr[i];
        end
        d.gset[q.pass] = q.shr[IDX_MIC_GAIN];
        d.pass = q.pass + 2'h1;
      end
    end
    if (reg_wr && reg_addr == OFS_SER_CTL) begin
      d.ser = reg_wdata[2:0];
    end

    // Shadow writes, register port over trim pins
    if (reg_wr) begin
      bw = pmc_sidx(reg_addr);
    end
    if (tw[4] && !(bw[4] && bw[3:0] == tw[3:0])) begin
      d.shr[tw[3:0]] = tword[7:0];
    end
    if (bw[4]) begin
      d.shr[bw[3:0]] = reg_wdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, valid one cycle after the strobe only
    d.rdata = 8'h00;
    if (reg_rd) begin
      if (pmc_sidx(reg_addr) != 5'h00) begin
        d.rdata = q.shr[pmc_sidx(reg_addr) & 5'h0f];
      end else if (reg_addr == OFS_SER_CTL) begin
        d.rdata = {5'h00, q.ser};
      end else if (reg_addr == OFS_STATUS) begin
        d.rdata = {2'h0, q.pass, q.base_pbo, q.lsn, q.mode};
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Amplifier controls follow the next state
    d.amp = '0;
    d.mode = MD_OFF;
    case (d.st)
      ST_START: begin
        d.amp.power_en = 1'b1;
      end
      ST_ANC, ST_LISTEN: begin
        d.mode = (d.st == ST_ANC) ? MD_ANC : MD_LSN;
        d.amp.power_en = 1'b1;
        d.amp.anc_en   = 1'b1;
        d.amp.mic_en   = 1'b1;
        d.amp.line_en  = 1'b1;
        d.amp.hp_en    = 1'b1;
        d.amp.opamp_en = d.shr[IDX_OPAMP][B_OPAMP_EN];
        d.amp.mic_gain = d.shr[IDX_MIC_GAIN];
        if (d.st == ST_LISTEN) begin
          d.amp.mic_gain  = d.shr[IDX_LSN_GAIN];
          d.amp.mux_alt   = d.shr[IDX_LSN_CFG][B_LSN_MUX];
          d.amp.line_mute = d.shr[IDX_LSN_CFG][B_LSN_MUTE];
        end
      end
      ST_PBO: begin
        d.mode = MD_PBO;
        d.amp.power_en  = 1'b1;
        d.amp.line_en   = 1'b1;
        d.amp.hp_en     = 1'b1;
        d.amp.opamp_en  = d.shr[IDX_OPAMP][B_OPAMP_EN];
        d.amp.line_mute = d.shr[IDX_PBO_CFG][B_PBO_MUTE];
        d.amp.mixer_sel = d.shr[IDX_PBO_CFG][B_PBO_MIXER];
      end
      default: begin
        d.mode = MD_OFF;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign op_mode   = q.mode;
  assign amp_ctl   = q.amp;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_fault_off;
    (running || q.st == ST_START) && fault |=> q.st == ST_OFF ##1 op_mode == MD_OFF;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("fault did not power down");

  property p_start;
    q.st == ST_OFF && !serial && q.armed && q.hi_cnt > CNT_W'(ON_CNT) |=> q.st == ST_START
      ##1 (q.st == ST_ANC || q.st == ST_PBO || q.st == ST_OFF);
  endproperty
  a_start: assert property (p_start) else $error("start-up sequence not run");

  property p_pbo_amps;
    q.st == ST_PBO |-> op_mode == MD_PBO && !amp_ctl.anc_en && !amp_ctl.mic_en
      && amp_ctl.line_en && amp_ctl.hp_en
      && amp_ctl.line_mute == q.shr[IDX_PBO_CFG][B_PBO_MUTE];
  endproperty
  a_pbo_amps: assert property (p_pbo_amps) else $error("playback amp set wrong");

  property p_lsn_gain;
    q.st == ST_LISTEN |-> amp_ctl.mic_gain == q.shr[IDX_LSN_GAIN] && op_mode == MD_LSN;
  endproperty
  a_lsn_gain: assert property (p_lsn_gain) else $error("listen gain not applied");

  property p_serial_lsn;
    running && serial && q.ser[B_KEEP_BIT] && q.ser[B_LSN_BIT] && !fault
      |=> q.st == ST_LISTEN;
  endproperty
  a_serial_lsn: assert property (p_serial_lsn) else $error("listen bit ignored");

  property p_keep_off;
    running && serial && !q.ser[B_KEEP_BIT] |=> q.st == ST_OFF;
  endproperty
  a_keep_off: assert property (p_keep_off) else $error("keep bit clear ignored");

  property p_slider_off;
    running && !serial && slider && q.lo_cnt >= CNT_W'(OFF_CNT) |=> q.st == ST_OFF;
  endproperty
  a_slider_off: assert property (p_slider_off) else $error("slider off missed");

  property p_block;
    q.st == ST_ANC && !serial && !full && !slider && q.shr[IDX_SCHEME][B_LSN_BLOCK]
      && !reg_wr |=> q.st != ST_LISTEN;
  endproperty
  a_block: assert property (p_block) else $error("blocked listen entered");

  property p_ncut;
    q.st == ST_START && !fault |=> q.st == ($past(q.s2[PIN_NCUT]) ? ST_ANC : ST_PBO);
  endproperty
  a_ncut: assert property (p_ncut) else $error("noise cut sample wrong");

  property p_fuse_mono;
    ##1 ($past(q.fuse) & ~q.fuse) == '0 && q.pass >= $past(q.pass);
  endproperty
  a_fuse_mono: assert property (p_fuse_mono) else $error("fuse bit cleared");

  c_pbo:    cover property (q.st == ST_START ##1 q.st == ST_PBO);
  c_lsn:    cover property (q.st == ST_ANC ##1 q.st == ST_LISTEN);
  c_store:  cover property (q.pass == 2'h2 ##1 q.pass == FUSE_PASSES);
  c_faulty: cover property (running && fault ##1 q.st == ST_OFF);

endmodule // pmc_top

// ---- power_mode_control_otp_tb.sv ----
// Self-checking bench for the power and mode controller.
// Assumes pmc_pkg, pmc_top and pmc_switch_model are compiled before it.
module power_mode_control_otp_tb
  import pmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        sys_clk, rstn, noise_cut_select_pin, negrail_overvolt_flag;
  logic        mode_sense_pin, mode_sense_mid, listen_button, trim_data_pin, trim_clock_pin;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd_v, g1, g2;
  logic        reg_wr, reg_rd;
  logic [1:0]  op_mode;
  pmc_amp_t    amp_ctl;
  logic [7:0]  sh [14];
  logic [31:0] rnd;
  int          err_count = 0;
  int          n_tests = 0;
  int          k;

  pmc_top #(.DEB_CNT(4), .ON_CNT(20), .OFF_CNT(40), .LONG_CNT(200)) pmc_top_inst (
    .sys_clk(sys_clk), .rstn(rstn), .mode_sense_pin(mode_sense_pin),
    .mode_sense_mid(mode_sense_mid), .listen_button(listen_button),
    .noise_cut_select_pin(noise_cut_select_pin), .negrail_overvolt_flag(negrail_overvolt_flag),
    .trim_data_pin(trim_data_pin), .trim_clock_pin(trim_clock_pin), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .op_mode(op_mode), .amp_ctl(amp_ctl));

  pmc_switch_model pmc_switch_model_inst (
    .sys_clk(sys_clk), .mode_sense_pin(mode_sense_pin), .mode_sense_mid(mode_sense_mid),
    .listen_button(listen_button), .trim_data_pin(trim_data_pin),
    .trim_clock_pin(trim_clock_pin));

  always #5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] sh_addr(input int i);
    return (i < 8) ? 8'h10 + 8'(i) : 8'h28 + 8'(i);
  endfunction

  task automatic chk(input string name, input logic [16:0] seen, input logic [16:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rd_v = reg_rdata;
  endtask

  task automatic rchk(input string name, input logic [7:0] ad, input logic [7:0] e);
    rd(ad);
    chk(name, 17'(rd_v), 17'(e));
  endtask

  // Polls the mode under a bounded count, then compares once
  task automatic wait_mode(input logic [1:0] e, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge sys_clk);
      #1;
      if (op_mode === e) break;
    end
    chk("op_mode", 17'(op_mode), 17'(e));
  endtask

  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    $display("watchdog expired");
    summarize();
  end

  ////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    noise_cut_select_pin = 1'b1;
    negrail_overvolt_flag = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rnd = 32'h8849;
    foreach (sh[j]) sh[j] = 8'h00;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("op_mode", 17'(op_mode), 17'h0);
    chk("amp_ctl", amp_ctl, 17'h0);
    rchk("status", OFS_STATUS, 8'h00);
    tdone("reset");
    // Push button scheme, fuses blank
    pmc_switch_model_inst.press(1'b0, 40);
    wait_mode(MD_ANC, 60);
    chk("amp_ctl", amp_ctl & 17'h18000, 17'h18000);
    pmc_switch_model_inst.press(1'b0, 15);
    wait_mode(MD_LSN, 30);
    pmc_switch_model_inst.press(1'b0, 15);
    wait_mode(MD_ANC, 30);
    wr(8'h15, 8'h04);
    pmc_switch_model_inst.press(1'b0, 15);
    repeat (30) @(posedge sys_clk);
    wait_mode(MD_ANC, 1);
    negrail_overvolt_flag <= 1'b1;
    wait_mode(MD_OFF, 6);
    chk("amp_ctl", amp_ctl, 17'h0);
    negrail_overvolt_flag <= 1'b0;
    rchk("block", 8'h15, 8'h00);
    pmc_switch_model_inst.press(1'b0, 40);
    wait_mode(MD_ANC, 60);
    pmc_switch_model_inst.press(1'b0, 220);
    wait_mode(MD_OFF, 10);
    tdone("button");
    // Serial control, random shadow traffic, first fuse pass
    wr(OFS_SER_CTL, 8'h06);
    wait_mode(MD_ANC, 10);
    for (int n = 0; n < 8; n++) begin
      rnd = lfsr(rnd);
      k = int'(rnd[7:0]) % 14;
      if (k == IDX_SCHEME) k = IDX_OPAMP;
      sh[k] = rnd[15:8];
      wr(sh_addr(k), sh[k]);
      rchk("shadow", sh_addr(k), sh[k]);
    end
    sh[1] = rnd[23:16];
    wr(8'h11, sh[1]);
    wr(8'h20, 8'hff);
    rchk("unmapped", 8'h20, 8'h00);
    pmc_switch_model_inst.trim_write(8'h12, 8'h03);
    rchk("trim", 8'h12, 8'h03);
    wr(OFS_SER_CTL, 8'h07);
    wait_mode(MD_LSN, 10);
    chk("amp_ctl", amp_ctl & 17'h106ff, {1'b1, 5'h00, 2'h3, 1'b0, sh[1]});
    g1 = rnd[31:24];
    wr(8'h10, g1);
    wr(8'h13, 8'h02);
    wr(8'h15, 8'h01);
    wr(OFS_FUSECMD, 8'h01);
    rd(OFS_STATUS);
    chk("pass", 17'(rd_v[5:4]), 17'h1);
    wr(OFS_SER_CTL, 8'h04);
    wait_mode(MD_OFF, 10);
    rchk("cleared", 8'h11, 8'h00);
    wr(OFS_SER_CTL, 8'h00);
    tdone("serial");
    // Slider scheme from fuses, playback base
    noise_cut_select_pin <= 1'b0;
    pmc_switch_model_inst.set_lvl(1'b1, 1'b1);
    wait_mode(MD_PBO, 60);
    chk("amp_ctl", amp_ctl & 17'h1fb00, {5'b10011, sh[4][0], 3'b001, 8'h00});
    rchk("scheme", 8'h15, 8'h01);
    rchk("gain", 8'h10, g1);
    pmc_switch_model_inst.press(1'b1, 15);
    wait_mode(MD_LSN, 30);
    repeat (50) @(posedge sys_clk);
    wait_mode(MD_LSN, 1);
    pmc_switch_model_inst.press(1'b1, 15);
    wait_mode(MD_PBO, 30);
    pmc_switch_model_inst.set_lvl(1'b0, 1'b0);
    repeat (30) @(posedge sys_clk);
    wait_mode(MD_PBO, 1);
    wait_mode(MD_OFF, 30);
    tdone("slider");
    // Later fuse passes only add bits; gain set follows the pass
    noise_cut_select_pin <= 1'b1;
    wr(OFS_SER_CTL, 8'h06);
    wait_mode(MD_ANC, 10);
    rnd = lfsr(rnd);
    g2 = rnd[7:0];
    wr(8'h10, g2);
    wr(8'h13, 8'h01);
    wr(8'h15, 8'h03);
    wr(OFS_FUSECMD, 8'h01);
    wr(OFS_FUSECMD, 8'h02);
    rchk("or", 8'h13, 8'h03);
    rchk("gain", 8'h10, g2);
    wr(OFS_FUSECMD, 8'h01);
    wr(OFS_FUSECMD, 8'h01);
    rd(OFS_STATUS);
    chk("pass", 17'(rd_v[5:4]), 17'h3);
    wr(OFS_SER_CTL, 8'h04);
    wait_mode(MD_OFF, 10);
    wr(OFS_SER_CTL, 8'h00);
    tdone("fuse");
    // Full slider scheme
    pmc_switch_model_inst.set_lvl(1'b1, 1'b1);
    wait_mode(MD_LSN, 60);
    pmc_switch_model_inst.set_lvl(1'b0, 1'b1);
    wait_mode(MD_ANC, 30);
    rchk("scheme", 8'h15, 8'h03);
    pmc_switch_model_inst.set_lvl(1'b0, 1'b0);
    wait_mode(MD_OFF, 70);
    tdone("full_slider");
    summarize();
  end
endmodule // power_mode_control_otp_tb
